// >>> bir_pkg.sv
// package for the bridge interrupt relay: message layout and widths
// assumes one core clock shared by both relay ends of an instance
`default_nettype none
package bir_pkg;
  // message kinds on the priority channel
  localparam logic [1:0] KIND_IRQ = 2'h1;
  localparam logic [1:0] KIND_ERR = 2'h2;
  // error payload bit positions
  localparam int ERR_LINK_BIT = 0;
  localparam int ERR_MULTI_BIT = 1;
  localparam int SYNC_STAGES = 2;
  localparam int IRQ_W_DEFAULT = 4;
  // reset value of the relayed interrupt outputs (o_irq)
  localparam logic RST_LEVEL = 1'b0;
endpackage
`default_nettype wire

// >>> bir_sync.sv
// two flop level synchroniser, vector wide
// assumes inputs come from outside the core clock domain
`default_nettype none
module bir_sync #(
  parameter int W = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta;
  logic [W-1:0] stage;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_stage;

  always_comb begin
    next_meta = i_async;
    next_stage = meta;
  end

  // meta is read only by the second stage
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta <= '0;
      stage <= '0;
    end else begin
      meta <= next_meta;
      stage <= next_stage;
    end
  end

  assign o_sync = stage;
endmodule
`default_nettype wire

// >>> bir_tx.sv
// priority message sender: one pending message, latest value wins
// assumes the link side answers with a one cycle accept pulse
`default_nettype none
module bir_tx #(
  parameter int W = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_load,
  input wire logic [W-1:0] i_data,
  input wire logic i_accept,
  output logic o_valid,
  output logic [W-1:0] o_data
);
  logic valid;
  logic [W-1:0] data;
  logic next_valid;
  logic [W-1:0] next_data;

  always_comb begin
    next_valid = valid;
    next_data = data;
    if (valid && i_accept) begin
      next_valid = 1'b0;
    end
    // a new load overrides an unsent value; load beats accept
    if (i_load) begin
      next_valid = 1'b1;
      next_data = i_data;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      valid <= 1'b0;
      data <= '0;
    end else begin
      valid <= next_valid;
      data <= next_data;
    end
  end

  assign o_valid = valid;
  assign o_data = data;
endmodule
`default_nettype wire

// >>> bir_relay.sv
// Function
// - interrupt levels travel on a dedicated channel ahead of ordinary bus traffic
// - both relay directions run independently, neither waits on the other
// - master input change sends new levels to slave-side outputs
// - slave input change sends new levels to master-side outputs
// - only the master side drives link-error outputs, for errors on either side
// - slave side reports each detected error to master over priority channel
// - slave reset during normal operation raises link-error at master
// - multibit errors at either side raise the multibit-error interrupt
// - on parallel pins multibit error is judged during deskew, meaning deskew failed
// - error flags are sticky, cleared by reset only
// - active-low global reset, may be asynchronous
//
// interrupt relay for one bridge instance; i_is_master picks the role
// assumes the link layer gives priority slots via i_link_ready and carries
// one message per accepted cycle; error detectors sit outside this block
`default_nettype none
module bir_relay #(
  parameter int IRQ_W = bir_pkg::IRQ_W_DEFAULT
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_is_master,
  input wire logic [IRQ_W-1:0] i_irq,
  output logic [IRQ_W-1:0] o_irq,
  input wire logic i_link_up,
  input wire logic i_deskew_active,
  input wire logic i_local_multibit,
  input wire logic i_local_link_err,
  input wire logic i_link_ready,
  output logic o_msg_valid,
  output logic [1:0] o_msg_kind,
  output logic [IRQ_W-1:0] o_msg_data,
  input wire logic i_msg_valid,
  input wire logic [1:0] i_msg_kind,
  input wire logic [IRQ_W-1:0] i_msg_data,
  input wire logic i_peer_reset_seen,
  output logic o_link_err_irq,
  output logic o_multibit_irq
);
  logic [IRQ_W-1:0] irq_sync;
  logic [IRQ_W-1:0] irq_prev;
  logic [IRQ_W-1:0] next_irq_prev;
  logic primed;
  logic next_primed;
  logic irq_load;
  logic irq_pend;
  logic [IRQ_W-1:0] irq_pdata;
  logic irq_accept;
  logic [1:0] err_ev;
  logic err_pend;
  logic [1:0] err_pdata;
  logic err_accept;
  logic [IRQ_W-1:0] next_o_irq;
  logic next_msg_valid;
  logic [1:0] next_msg_kind;
  logic [IRQ_W-1:0] next_msg_data;
  logic next_link_err;
  logic next_multibit;
  logic [1:0] err_acc;
  logic [1:0] next_err_acc;
  logic local_mb;
  logic rx_irq;
  logic rx_err;

  function automatic logic [IRQ_W-1:0] widen_err(input logic [1:0] e);
    logic [IRQ_W-1:0] r;
    r = '0;
    r[1:0] = e;
    return r;
  endfunction

  // multibit errors count only inside the deskew window
  function automatic logic deskew_fail(input logic mb, input logic dsk);
    return mb && dsk;
  endfunction

  function automatic logic msg_is(input logic v, input logic [1:0] k, input logic [1:0] code);
    return v && (k == code);
  endfunction

  bir_sync #(.W(IRQ_W)) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_async(i_irq),
    .o_sync(irq_sync)
  );

  // first cycle after reset sends the levels once so the far side starts right
  assign irq_load = !primed || (irq_sync != irq_prev);

  bir_tx #(.W(IRQ_W)) u_irq_tx (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_load(irq_load),
    .i_data(irq_sync),
    .i_accept(irq_accept),
    .o_valid(irq_pend),
    .o_data(irq_pdata)
  );

  // decodes used by the error collector, the flag logic and the receive path
  assign local_mb = deskew_fail(i_local_multibit, i_deskew_active);
  assign rx_irq = msg_is(i_msg_valid, i_msg_kind, bir_pkg::KIND_IRQ);
  assign rx_err = msg_is(i_msg_valid, i_msg_kind, bir_pkg::KIND_ERR);

  // change detect state
  always_comb begin
    next_irq_prev = irq_sync;
    next_primed = 1'b1;
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_prev <= '0;
      primed <= 1'b0;
    end else begin
      irq_prev <= next_irq_prev;
      primed <= next_primed;
    end
  end

  // slave side collects error events, accumulating until sent
  always_comb begin
    err_ev = 2'h0;
    err_ev[bir_pkg::ERR_LINK_BIT] = i_local_link_err;
    err_ev[bir_pkg::ERR_MULTI_BIT] = local_mb;
    next_err_acc = err_acc;
    if (err_accept) begin
      next_err_acc = 2'h0;
    end
    // a new event in the send cycle is kept, not lost
    next_err_acc = next_err_acc | (i_is_master ? 2'h0 : err_ev);
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      err_acc <= 2'h0;
    end else begin
      err_acc <= next_err_acc;
    end
  end

  assign err_pend = (err_acc != 2'h0);
  assign err_pdata = err_acc;

  // error messages first, they are rare; irq waits one slot at most per error
  assign err_accept = !o_msg_valid && i_link_ready && err_pend;
  assign irq_accept = !o_msg_valid && i_link_ready && !err_pend && irq_pend;

  // outgoing message register
  always_comb begin
    next_msg_valid = 1'b0;
    next_msg_kind = o_msg_kind;
    next_msg_data = o_msg_data;
    if (err_accept) begin
      next_msg_valid = 1'b1;
      next_msg_kind = bir_pkg::KIND_ERR;
      next_msg_data = widen_err(err_pdata);
    end else if (irq_accept) begin
      next_msg_valid = 1'b1;
      next_msg_kind = bir_pkg::KIND_IRQ;
      next_msg_data = irq_pdata;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_msg_valid <= 1'b0;
      o_msg_kind <= 2'h0;
      o_msg_data <= '0;
    end else begin
      o_msg_valid <= next_msg_valid;
      o_msg_kind <= next_msg_kind;
      o_msg_data <= next_msg_data;
    end
  end

  // receive path is independent of the transmit path
  always_comb begin
    next_o_irq = o_irq;
    if (rx_irq) begin
      next_o_irq = i_msg_data;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_irq <= {IRQ_W{bir_pkg::RST_LEVEL}};
    end else begin
      o_irq <= next_o_irq;
    end
  end

  // link-error flag, master only; peer reset counts only with the link up
  always_comb begin
    next_link_err = o_link_err_irq;
    if (i_is_master) begin
      if (i_local_link_err) begin
        next_link_err = 1'b1;
      end
      if (i_peer_reset_seen && i_link_up) begin
        next_link_err = 1'b1;
      end
      if (rx_err && i_msg_data[bir_pkg::ERR_LINK_BIT]) begin
        next_link_err = 1'b1;
      end
    end
    // no clear path: sticky until reset
    next_link_err = next_link_err | o_link_err_irq;
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_link_err_irq <= 1'b0;
    end else begin
      o_link_err_irq <= next_link_err;
    end
  end

  // multibit flag, master only; local or reported by the slave
  always_comb begin
    next_multibit = o_multibit_irq;
    if (i_is_master) begin
      if (local_mb) begin
        next_multibit = 1'b1;
      end
      if (rx_err && i_msg_data[bir_pkg::ERR_MULTI_BIT]) begin
        next_multibit = 1'b1;
      end
    end
    next_multibit = next_multibit | o_multibit_irq;
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_multibit_irq <= 1'b0;
    end else begin
      o_multibit_irq <= next_multibit;
    end
  end
endmodule
`default_nettype wire

// >>> bir_relay_checker.sv
// port checker for the interrupt relay
// assumes it is bound onto every bir_relay instance
`default_nettype none
module bir_relay_checker #(
  parameter int IRQ_W = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_is_master,
  input wire logic i_link_up,
  input wire logic i_deskew_active,
  input wire logic i_local_multibit,
  input wire logic i_link_ready,
  input wire logic i_msg_valid,
  input wire logic [1:0] i_msg_kind,
  input wire logic [IRQ_W-1:0] i_msg_data,
  input wire logic i_peer_reset_seen,
  input wire logic [IRQ_W-1:0] o_irq,
  input wire logic o_msg_valid,
  input wire logic o_link_err_irq,
  input wire logic o_multibit_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  wire logic irq_in = i_msg_valid && i_msg_kind == bir_pkg::KIND_IRQ;
  wire logic err_mb = i_msg_valid && i_msg_kind == bir_pkg::KIND_ERR && i_msg_data[bir_pkg::ERR_MULTI_BIT];
  a_msg_one_cycle: assert property (o_msg_valid |=> !o_msg_valid) else $error("message pulse too long");
  a_msg_needs_slot: assert property ($rose(o_msg_valid) |-> $past(i_link_ready)) else $error("sent without slot");
  a_irq_follows_msg: assert property (irq_in |=> o_irq == $past(i_msg_data)) else $error("irq outputs stale");
  a_slave_no_flags: assert property (!i_is_master |-> !o_link_err_irq && !o_multibit_irq) else $error("slave flag");
  a_peer_reset_flag: assert property (i_is_master && i_link_up && i_peer_reset_seen |=> o_link_err_irq)
    else $error("peer reset missed");
  a_deskew_multibit: assert property (i_is_master && i_deskew_active && i_local_multibit |=> o_multibit_irq)
    else $error("deskew multibit missed");
  a_remote_multibit: assert property (i_is_master && err_mb |=> o_multibit_irq) else $error("remote multibit missed");
  a_link_sticky: assert property (o_link_err_irq |=> o_link_err_irq) else $error("link flag dropped");
  a_multi_sticky: assert property (o_multibit_irq |=> $stable(o_multibit_irq)) else $error("multibit flag dropped");
  c_irq_in: cover property (irq_in);
  c_link_flag: cover property ($rose(o_link_err_irq));
  c_slave_send: cover property ($rose(o_msg_valid) && !i_is_master);
endmodule
bind bir_relay bir_relay_checker #(.IRQ_W(IRQ_W)) bir_relay_checker_inst (.*);
`default_nettype wire

// >>> bir_peer.sv
// partner model: far bridge end on the priority channel
// assumes one-cycle message pulses from the relay
`default_nettype none
module bir_peer (
  input wire logic i_sys_clk,
  input wire logic i_stall,
  input wire logic i_send,
  input wire logic [1:0] i_kind,
  input wire logic [3:0] i_data,
  input wire logic i_rx_valid,
  input wire logic [1:0] i_rx_kind,
  input wire logic [3:0] i_rx_data,
  output logic o_ready,
  output logic o_valid,
  output logic [1:0] o_kind,
  output logic [3:0] o_data,
  output logic [1:0] o_last_kind,
  output logic [3:0] o_last_data
);
  timeunit 1ns;
  timeprecision 1ns;
  assign o_ready = !i_stall;
  initial begin
    o_valid = 1'b0;
    o_kind = 2'h0;
    o_data = 4'h0;
  end
  always @(posedge i_sys_clk) begin
    o_valid <= i_send;
    // idle lines toggle so a stale value is never mistaken for a message
    o_kind <= i_send ? i_kind : ~o_kind;
    o_data <= i_send ? i_data : ~o_data;
    if (i_rx_valid) begin
      o_last_kind <= i_rx_kind;
      o_last_data <= i_rx_data;
    end
  end
endmodule
`default_nettype wire

// >>> tb_bir_relay.sv
// self-checking bench for one relay facing a peer model
// assumes 50 MHz core clock and the package message codes
`default_nettype none
module tb_bir_relay;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, mst = 1, dsk = 0, lmb = 0, lle = 0, prs = 0, stall = 0, snd = 0, lup = 1;
  logic [3:0] irq = 4'h0, sdata = 4'h0, oirq, odata, mdata, ldata;
  logic [1:0] skind = 2'h0, okind, mkind, lkind;
  logic rdy, ov, mv, le, mb;
  int num_errors = 0, samples_checked = 0;
  bir_peer bir_peer_inst (.i_sys_clk(clk), .i_stall(stall), .i_send(snd), .i_kind(skind), .i_data(sdata),
    .i_rx_valid(ov), .i_rx_kind(okind), .i_rx_data(odata), .o_ready(rdy), .o_valid(mv), .o_kind(mkind),
    .o_data(mdata), .o_last_kind(lkind), .o_last_data(ldata));
  bir_relay #(.IRQ_W(4)) bir_relay_inst (.i_sys_clk(clk), .i_reset_n(rst_n), .i_is_master(mst), .i_irq(irq),
    .o_irq(oirq), .i_link_up(lup), .i_deskew_active(dsk), .i_local_multibit(lmb), .i_local_link_err(lle),
    .i_link_ready(rdy), .o_msg_valid(ov), .o_msg_kind(okind), .o_msg_data(odata), .i_msg_valid(mv),
    .i_msg_kind(mkind), .i_msg_data(mdata), .i_peer_reset_seen(prs), .o_link_err_irq(le), .o_multibit_irq(mb));
  initial forever #10 clk = ~clk;
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rst_dut(input logic m);
    @(negedge clk) rst_n = 0;
    mst = m;
    repeat (8) @(negedge clk);
    rst_n = 1;
    repeat (10) @(negedge clk);
  endtask
  task automatic send(input logic [1:0] k, input logic [3:0] d);
    @(negedge clk) snd = 1;
    skind = k;
    sdata = d;
    @(negedge clk) snd = 0;
    @(negedge clk);
  endtask
  task automatic t_master_irq;
    rst_dut(1);
    irq = 4'ha;
    repeat (8) @(negedge clk);
    chk(ldata, 4'ha);
    chk({2'h0, lkind}, {2'h0, bir_pkg::KIND_IRQ});
    stall = 1;
    irq = 4'h3;
    repeat (6) @(negedge clk);
    send(bir_pkg::KIND_IRQ, 4'h6);
    chk(oirq, 4'h6);
    irq = 4'h5;
    repeat (6) @(negedge clk);
    chk(ldata, 4'ha);
    stall = 0;
    repeat (8) @(negedge clk);
    chk(ldata, 4'h5);
  endtask
  task automatic t_master_flags;
    rst_dut(1);
    lmb = 1;
    repeat (3) @(negedge clk);
    chk({3'h0, mb}, 4'h0);
    dsk = 1;
    @(negedge clk) chk({3'h0, mb}, 4'h1);
    lmb = 0;
    dsk = 0;
    repeat (4) @(negedge clk);
    chk({3'h0, mb}, 4'h1);
    send(bir_pkg::KIND_ERR, 4'h1);
    chk({3'h0, le}, 4'h1);
    rst_dut(1);
    chk({2'h0, le, mb}, 4'h0);
    send(bir_pkg::KIND_ERR, 4'h2);
    chk({2'h0, le, mb}, 4'h1);
    lup = 0;
    prs = 1;
    @(negedge clk) chk({3'h0, le}, 4'h0);
    lup = 1;
    @(negedge clk) prs = 0;
    @(negedge clk) chk({3'h0, le}, 4'h1);
  endtask
  task automatic t_slave;
    rst_dut(0);
    lle = 1;
    @(negedge clk) lle = 0;
    repeat (8) @(negedge clk);
    chk({2'h0, lkind}, {2'h0, bir_pkg::KIND_ERR});
    chk({3'h0, ldata[bir_pkg::ERR_LINK_BIT]}, 4'h1);
    chk({3'h0, le}, 4'h0);
    irq = 4'h7;
    repeat (8) @(negedge clk);
    chk(ldata, 4'h7);
  endtask
  task automatic complete_run;
    if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    complete_run;
  end
  initial begin
    t_master_irq;
    t_master_flags;
    t_slave;
    complete_run;
  end
endmodule
`default_nettype wire
